// file: common/smf_defines.svh
// constants of the satellite measurement framer
// assumes inclusion by bare name from the rtl files and the bench
// Functional notes
// - record per tracked satellite above mask
// - record opens with fixed header and identifier
// - 2-byte epoch tag, 50 ms, mod 30 min
// - count of records still to come
// - satellite number then elevation degrees
// - azimuth: binary 2-degree steps, text degrees
// - channel index one to twelve
// - three identical 29-byte code blocks
// - block opens with warning, then quality
// - third block byte is constant five
// - signal-to-noise byte, then spare byte
// - 8-byte double carrier phase
// - 8-byte double raw range seconds
// - 4-byte signed Doppler
// - smoothing correction magnitude and sign
// - smoothing count in top byte
// - XOR checksum byte, 97 bytes after the header
// - text form: 36 fields plus checksum
// - every record ends CR then LF
// - commas separate header, identifier, data
`ifndef SMF_DEFINES_SVH
`define SMF_DEFINES_SVH
`define SMF_CLK_NS 8
`define SMF_TAG_NS 50000000
`define SMF_TAG_MOD 16'h8CA0
`define SMF_NCH 12
`define SMF_IMG_LEN 94
`define SMF_BLK_LEN 29
`define SMF_BLK0 7
`define SMF_COMPAT 8'h05
`define SMF_BIN_TOTAL 97
`define SMF_HDR_LEN 11
`define SMF_HDR 88'h24_50_41_53_48_52_2C_4D_50_43_2C
`define SMF_NFLD 36
`define SMF_CK_DIG 5'h03
`define SMF_CR 8'h0D
`define SMF_LF 8'h0A
`define SMF_COMMA 8'h2C
`define SMF_MINUS 8'h2D
`define SMF_DOT 8'h2E
`define SMF_ZERO 8'h30
`define SMF_FIFO_D 16
`endif

// file: common/smf_pkg.sv
// types of the satellite measurement framer
// assumes nothing beyond the compile order
package smf_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_SCAN = 4'h1, S_REQ = 4'h2, S_HDR = 4'h3,
		S_BIN = 4'h4, S_FLD = 4'h5, S_CONV = 4'h6, S_SEP = 4'h7,
		S_CKS = 4'h8, S_CKC = 4'h9, S_CR = 4'hA, S_LF = 4'hB
	} smf_st_t;
	typedef enum logic [1:0] {
		C_IDLE = 2'h0, C_DIV = 2'h1, C_OUT = 2'h2
	} smf_cst_t;
	typedef logic [7:0] smf_byte_t;
endpackage

// file: common/smf_strm_if.sv
// byte stream between framer parts, taken when valid and ready are high
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface smf_strm_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// file: rtl/smf_fifo.sv
// output byte queue of the framer
// assumes the drain side may stall at any time
`timescale 1ns/1ps
`include "smf_defines.svh"
module smf_fifo #(
	parameter int W = 8,
	parameter int D = `SMF_FIFO_D
) (
	input wire logic mclk,
	input wire logic arst_n,
	smf_strm_if.snk in_s,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin
		$error("fifo depth must be a power of two");
	end
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic wr;
	logic rd;
	assign in_s.ready = cnt_q != (AW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign wr = in_s.valid && in_s.ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) wp_q <= wp_q + 1'b1;
			if (rd) rp_q <= rp_q + 1'b1;
			if (wr && !rd) cnt_q <= cnt_q + 1'b1;
			else if (rd && !wr) cnt_q <= cnt_q - 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (wr) mem_q[wp_q] <= in_s.data;
	end
endmodule

// file: rtl/smf_dec.sv
// unsigned value to decimal text, with optional sign and decimal point
// assumes start only while busy is low and mind within DIG
`timescale 1ns/1ps
`include "smf_defines.svh"
module smf_dec #(
	parameter int DIG = 20
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [63:0] mag,
	input wire logic neg,
	input wire logic [3:0] dec,
	input wire logic [4:0] mind,
	output logic busy,
	smf_strm_if.src o
);
	import smf_pkg::*;
	if (DIG < 20 || DIG > 31) begin
		$error("digit buffer cannot hold a 64-bit value");
	end
	smf_cst_t st_q;
	logic [63:0] v_q;
	logic [3:0] dg_q [DIG];
	logic [4:0] n_q;
	logic sg_q;
	logic dt_q;
	logic [3:0] dec_q;
	logic [4:0] mind_q;
	logic [63:0] quo;
	logic dot;
	// one digit per cycle; divider by a constant keeps it shallow
	assign quo = v_q / 64'hA;
	assign dot = dec_q != 4'h0 && n_q == 5'(dec_q) && !dt_q && !sg_q;
	assign busy = st_q != C_IDLE;
	assign o.valid = st_q == C_OUT;
	always_comb begin
		if (sg_q) o.data = `SMF_MINUS;
		else if (dot) o.data = `SMF_DOT;
		else o.data = `SMF_ZERO | {4'h0, dg_q[n_q - 5'h01]};
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= C_IDLE;
			v_q <= '0;
			n_q <= '0;
			sg_q <= 1'b0;
			dt_q <= 1'b0;
			dec_q <= '0;
			mind_q <= '0;
		end else begin
			case (st_q)
			C_IDLE: begin
				if (start) begin
					v_q <= mag;
					sg_q <= neg;
					dec_q <= dec;
					mind_q <= mind;
					n_q <= '0;
					dt_q <= 1'b0;
					st_q <= C_DIV;
				end
			end
			C_DIV: begin
				n_q <= n_q + 5'h01;
				v_q <= quo;
				if (quo == 64'h0 && n_q + 5'h01 >= mind_q) st_q <= C_OUT;
			end
			C_OUT: begin
				if (o.ready) begin
					if (sg_q) sg_q <= 1'b0;
					else if (dot) dt_q <= 1'b1;
					else begin
						n_q <= n_q - 5'h01;
						if (n_q == 5'h01) st_q <= C_IDLE;
					end
				end
			end
			default: st_q <= C_IDLE;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (st_q == C_DIV) dg_q[n_q] <= 4'(v_q - quo * 64'hA);
	end
endmodule

// file: rtl/smf_framer.sv
// satellite measurement framer: each epoch walks the channels, asks the
// measurement engine for every qualifying satellite and frames a record
// in binary or text form into the output byte queue
// assumes meas_* data is valid in the cycle meas_ack is high
`timescale 1ns/1ps
`include "smf_defines.svh"
module smf_framer #(
	parameter int NCH = `SMF_NCH,
	parameter int TAG_CYC = `SMF_TAG_NS / `SMF_CLK_NS,
	parameter int FIFO_D = `SMF_FIFO_D
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ascii_mode,
	input wire logic epoch_start,
	input wire logic [NCH-1:0] trk,
	input wire logic [NCH*8-1:0] elev,
	input wire logic [7:0] elev_mask,
	output logic meas_req,
	output logic [3:0] meas_ch,
	input wire logic meas_ack,
	input wire logic [7:0] meas_prn,
	input wire logic [8:0] meas_az_deg,
	input wire logic [23:0] meas_warn,
	input wire logic [23:0] meas_qual,
	input wire logic [23:0] meas_snr,
	input wire logic [191:0] meas_phase,
	input wire logic [191:0] meas_range,
	input wire logic [95:0] meas_dopp,
	input wire logic [95:0] meas_smooth,
	input wire logic [191:0] meas_phase_mc,
	input wire logic [191:0] meas_ttime_fx,
	output logic busy,
	output logic tx_valid,
	input wire logic tx_ready,
	output smf_pkg::smf_byte_t tx_data
);
	import smf_pkg::*;
	if (NCH < 1 || NCH > 15 || TAG_CYC < 1) begin
		$error("channel count or tag period out of range");
	end
	localparam logic [87:0] HDR = `SMF_HDR;
	localparam int IL = `SMF_IMG_LEN;
	localparam int BL = `SMF_BLK_LEN;
	localparam int B0 = `SMF_BLK0;
	localparam logic [6:0] CKI = 7'(IL);
	localparam logic [6:0] HLI = 7'(`SMF_HDR_LEN - 1);

	smf_st_t st_q;
	logic asc_q;
	logic [15:0] tag_q;
	logic [15:0] etag_q;
	logic [31:0] tk_q;
	logic tick;
	logic [NCH-1:0] qual;
	logic [NCH-1:0] qual_q;
	logic [NCH*8-1:0] elv_q;
	logic [3:0] ch_q;
	logic [3:0] cnt_q;
	logic [6:0] idx_q;
	logic [5:0] fld_q;
	logic [7:0] ck_q;
	logic [7:0] img_q [IL];
	logic [7:0] img_d [IL];
	logic [8:0] az_q;
	logic [63:0] pmc_q [3];
	logic [63:0] tt_q [3];
	logic cv_start;
	logic [63:0] cv_mag;
	logic cv_neg;
	logic [3:0] cv_dec;
	logic [4:0] cv_mind;
	logic cv_busy;
	logic acc;
	logic [7:0] rc_q;
	logic [7:0] hx_q;
	logic [5:0] sep_q;

	smf_strm_if #(.W(8)) fq();
	smf_strm_if #(.W(8)) cv();

	function automatic logic [3:0] pop(input logic [NCH-1:0] v);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < NCH; i++) n = n + 4'(v[i]);
		return n;
	endfunction

	for (genvar i = 0; i < NCH; i++) begin : g_q
		// strictly above the mask qualifies
		assign qual[i] = trk[i] && elev[i*8 +: 8] > elev_mask;
	end

	assign acc = fq.valid && fq.ready;
	assign busy = st_q != S_IDLE;
	assign meas_req = st_q == S_REQ;
	assign meas_ch = ch_q + 4'h1;
	assign cv_start = st_q == S_FLD || st_q == S_CKS;
	assign tick = tk_q == 32'(TAG_CYC - 1);

	// free-running 50 ms tag, sampled once per epoch
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tk_q <= '0;
			tag_q <= '0;
		end else if (tick) begin
			tk_q <= '0;
			if (tag_q == `SMF_TAG_MOD - 16'h0001) tag_q <= '0;
			else tag_q <= tag_q + 16'h0001;
		end else begin
			tk_q <= tk_q + 32'h1;
		end
	end

	// epoch start while a previous epoch still runs is dropped
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			qual_q <= '0;
			elv_q <= '0;
			asc_q <= 1'b0;
			etag_q <= '0;
			cnt_q <= '0;
		end else if (st_q == S_IDLE && epoch_start) begin
			qual_q <= qual;
			elv_q <= elev;
			asc_q <= ascii_mode;
			etag_q <= tag_q;
			cnt_q <= pop(qual);
		end else if (st_q == S_LF && acc) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	always_comb begin
		for (int k = 0; k < IL; k++) img_d[k] = 8'h00;
		img_d[0] = etag_q[15:8];
		img_d[1] = etag_q[7:0];
		img_d[2] = 8'(cnt_q - 4'h1);
		img_d[3] = meas_prn;
		img_d[4] = elv_q[ch_q*8 +: 8];
		img_d[5] = meas_az_deg[8:1];
		img_d[6] = 8'(meas_ch);
		for (int b = 0; b < 3; b++) begin
			img_d[B0+BL*b] = meas_warn[b*8 +: 8];
			img_d[B0+BL*b+1] = meas_qual[b*8 +: 8];
			img_d[B0+BL*b+2] = `SMF_COMPAT;
			img_d[B0+BL*b+3] = meas_snr[b*8 +: 8];
			for (int j = 0; j < 8; j++) begin
				img_d[B0+BL*b+5+j] = meas_phase[b*64+56-8*j +: 8];
				img_d[B0+BL*b+13+j] = meas_range[b*64+56-8*j +: 8];
			end
			for (int j = 0; j < 4; j++) begin
				img_d[B0+BL*b+21+j] = meas_dopp[b*32+24-8*j +: 8];
				// bit 23 sign and 22..0 centimetres pass as given
				img_d[B0+BL*b+25+j] = meas_smooth[b*32+24-8*j +: 8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (st_q == S_REQ && meas_ack) begin
			for (int k = 0; k < IL; k++) img_q[k] <= img_d[k];
			az_q <= meas_az_deg;
			for (int b = 0; b < 3; b++) begin
				pmc_q[b] <= meas_phase_mc[b*64 +: 64];
				tt_q[b] <= meas_ttime_fx[b*64 +: 64];
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_IDLE;
			ch_q <= '0;
			idx_q <= '0;
			fld_q <= '0;
		end else begin
			case (st_q)
			S_IDLE: begin
				if (epoch_start) begin
					st_q <= S_SCAN;
					ch_q <= '0;
				end
			end
			S_SCAN: begin
				if (ch_q == 4'(NCH)) st_q <= S_IDLE;
				else if (qual_q[ch_q]) st_q <= S_REQ;
				else ch_q <= ch_q + 4'h1;
			end
			S_REQ: begin
				if (meas_ack) begin
					st_q <= S_HDR;
					idx_q <= '0;
				end
			end
			S_HDR: begin
				if (acc && idx_q == HLI) begin
					idx_q <= '0;
					fld_q <= 6'h01;
					st_q <= asc_q ? S_FLD : S_BIN;
				end else if (acc) begin
					idx_q <= idx_q + 7'h01;
				end
			end
			S_BIN: begin
				if (acc && idx_q == CKI) st_q <= S_CR;
				else if (acc) idx_q <= idx_q + 7'h01;
			end
			S_FLD: st_q <= S_CONV;
			S_CONV: begin
				if (!cv_busy) st_q <= S_SEP;
			end
			S_SEP: begin
				if (acc && fld_q == 6'(`SMF_NFLD)) begin
					st_q <= S_CKS;
				end else if (acc) begin
					fld_q <= fld_q + 6'h01;
					st_q <= S_FLD;
				end
			end
			S_CKS: st_q <= S_CKC;
			S_CKC: begin
				if (!cv_busy) st_q <= S_CR;
			end
			S_CR: begin
				if (acc) st_q <= S_LF;
			end
			S_LF: begin
				if (acc) begin
					st_q <= S_SCAN;
					ch_q <= ch_q + 4'h1;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// the text checksum is printed, so it must stop before itself
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ck_q <= '0;
		end else if (st_q == S_HDR) begin
			ck_q <= '0;
		end else if (acc && (st_q == S_CONV || st_q == S_SEP)) begin
			ck_q <= ck_q ^ fq.data;
		end else if (acc && st_q == S_BIN && idx_q != CKI) begin
			ck_q <= ck_q ^ fq.data;
		end
	end

	always_comb begin
		fq.valid = 1'b0;
		fq.data = 8'h00;
		cv.ready = 1'b0;
		case (st_q)
		S_HDR: begin
			fq.valid = 1'b1;
			fq.data = HDR[8*(`SMF_HDR_LEN-1-int'(idx_q)) +: 8];
		end
		S_BIN: begin
			fq.valid = 1'b1;
			fq.data = idx_q == CKI ? ck_q : img_q[idx_q];
		end
		S_CONV, S_CKC: begin
			fq.valid = cv.valid;
			fq.data = cv.data;
			cv.ready = fq.ready;
		end
		S_SEP: begin
			fq.valid = 1'b1;
			fq.data = `SMF_COMMA;
		end
		S_CR: begin
			fq.valid = 1'b1;
			fq.data = `SMF_CR;
		end
		S_LF: begin
			fq.valid = 1'b1;
			fq.data = `SMF_LF;
		end
		default: begin
			fq.valid = 1'b0;
		end
		endcase
	end

	// text field values, fixed-point sources give the decimal places
	always_comb begin
		logic [5:0] f;
		logic [1:0] b;
		logic [3:0] s;
		int o;
		logic [31:0] wd;
		logic [31:0] ws;
		f = fld_q < 6'h07 ? 6'h00 : fld_q - 6'h07;
		b = 2'(f / 6'hA);
		s = 4'(f % 6'hA);
		o = B0 + BL * int'(b);
		wd = {img_q[o+21], img_q[o+22], img_q[o+23], img_q[o+24]};
		ws = {img_q[o+25], img_q[o+26], img_q[o+27], img_q[o+28]};
		cv_mag = 64'h0;
		cv_neg = 1'b0;
		cv_dec = 4'h0;
		if (st_q == S_CKS) begin
			cv_mag = 64'(ck_q);
		end else if (fld_q == 6'h01) begin
			cv_mag = 64'(etag_q);
		end else if (fld_q == 6'h05) begin
			cv_mag = 64'(az_q);
		end else if (fld_q < 6'h07) begin
			cv_mag = 64'(img_q[fld_q[2:0]]);
		end else begin
			case (s)
			4'h5: begin
				cv_neg = pmc_q[b][63];
				cv_mag = cv_neg ? -pmc_q[b] : pmc_q[b];
				cv_dec = 4'h3;
			end
			4'h6: begin
				cv_mag = tt_q[b];
				cv_dec = 4'h7;
			end
			4'h7: begin
				cv_neg = wd[31];
				cv_mag = 64'(wd[31] ? -wd : wd);
			end
			4'h8: begin
				cv_neg = ws[23];
				cv_mag = 64'(ws[22:0]);
				cv_dec = 4'h2;
			end
			4'h9: cv_mag = 64'(ws[31:24]);
			default: cv_mag = 64'(img_q[o + int'(s)]);
			endcase
		end
		cv_mind = st_q == S_CKS ? `SMF_CK_DIG : 5'(cv_dec) + 5'h01;
	end

	smf_dec #(.DIG(20)) u_dec (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(cv_start),
		.mag(cv_mag),
		.neg(cv_neg),
		.dec(cv_dec),
		.mind(cv_mind),
		.busy(cv_busy),
		.o(cv)
	);

	smf_fifo #(.W(8), .D(FIFO_D)) u_fifo (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_s(fq),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	// helpers watched only by the checks below
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rc_q <= '0;
			hx_q <= '0;
			sep_q <= '0;
		end else if (st_q == S_HDR) begin
			rc_q <= '0;
			hx_q <= '0;
			sep_q <= '0;
		end else if (acc) begin
			rc_q <= rc_q + 8'h01;
			if (st_q == S_BIN) hx_q <= hx_q ^ fq.data;
			if (st_q == S_SEP) sep_q <= sep_q + 6'h01;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	AST_CRLF: assert property (
		st_q == S_CR && acc |=> st_q == S_LF && fq.data == `SMF_LF)
		else $error("line feed does not follow carriage return");
	AST_BIN_LEN: assert property (
		st_q == S_LF && acc && !asc_q |-> rc_q == 8'(`SMF_BIN_TOTAL - 1))
		else $error("binary record length wrong");
	AST_XOR: assert property (
		$rose(st_q == S_CR) && !asc_q |-> hx_q == 8'h00)
		else $error("binary checksum does not cancel");
	AST_FIVE: assert property (
		st_q == S_BIN && acc && (idx_q == 7'h09 || idx_q == 7'h26 ||
		idx_q == 7'h43) |-> fq.data == `SMF_COMPAT)
		else $error("compatibility byte not five");
	AST_REM: assert property (
		st_q == S_REQ && meas_ack |->
		img_d[2] == 8'(pop(qual_q >> (ch_q + 4'h1))))
		else $error("remaining count wrong");
	AST_SEL: assert property (
		$rose(meas_req) |-> qual_q[ch_q] && $past(st_q) == S_SCAN)
		else $error("request for a channel that does not qualify");
	AST_HDR: assert property (
		$rose(st_q == S_BIN || st_q == S_FLD) |->
		$past(fq.data) == `SMF_COMMA && $past(acc))
		else $error("header not closed by a comma");
	AST_FLDS: assert property (
		st_q == S_CKS |-> sep_q == 6'(`SMF_NFLD))
		else $error("text record field count wrong");
	AST_TAG: assert property (
		tick && tag_q == `SMF_TAG_MOD - 16'h0001 |=> tag_q == 16'h0000)
		else $error("epoch tag did not wrap");
endmodule

// file: verification/smf_term_model.sv
// terminal model: drains the framer's byte stream into a queue
// assumes the bench reads q hierarchically; stall slows the drain
`timescale 1ns/1ps
module smf_term_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic stall
);
	logic [7:0] q[$];
	logic [2:0] ph_q;
	initial begin
		tx_ready = 1'b0;
		ph_q = 3'h0;
	end
	// refusing five cycles in eight lets the output queue fill up
	always @(negedge mclk) begin
		ph_q <= ph_q + 3'h1;
		tx_ready <= arst_n && !(stall && ph_q < 3'h5);
	end
	always @(posedge mclk) begin
		if (tx_valid && tx_ready) begin
			q.push_back(tx_data);
		end
	end
endmodule

// file: verification/tb_satellite_measurement_framer.sv
// bench of the framer: engine model inline, terminal model instanced
// assumes TAG_CYC shortened to 8 cycles for the tag scenario
`timescale 1ns/1ps
`include "smf_defines.svh"
module tb_satellite_measurement_framer;
	logic mclk, arst_n, ascii_mode, epoch_start, meas_req, meas_ack;
	logic busy, tx_valid, tx_ready, stall;
	logic [11:0] trk;
	logic [95:0] elev, meas_dopp, meas_smooth;
	logic [7:0] elev_mask, meas_prn;
	logic [3:0] meas_ch;
	logic [8:0] meas_az_deg;
	logic [23:0] meas_warn, meas_qual, meas_snr;
	logic [191:0] meas_phase, meas_range, meas_phase_mc, meas_ttime_fx;
	smf_pkg::smf_byte_t tx_data;
	logic [1:0] dly;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	int ep_cyc = 0;
	int rel_cyc = 0;
	// tag period shortened so that tag steps show within a short run
	localparam int TC = 8;

	smf_framer #(.TAG_CYC(TC)) dut_u (.mclk(mclk), .arst_n(arst_n),
		.ascii_mode(ascii_mode), .epoch_start(epoch_start), .trk(trk),
		.elev(elev), .elev_mask(elev_mask), .meas_req(meas_req),
		.meas_ch(meas_ch), .meas_ack(meas_ack), .meas_prn(meas_prn),
		.meas_az_deg(meas_az_deg), .meas_warn(meas_warn),
		.meas_qual(meas_qual), .meas_snr(meas_snr),
		.meas_phase(meas_phase), .meas_range(meas_range),
		.meas_dopp(meas_dopp), .meas_smooth(meas_smooth),
		.meas_phase_mc(meas_phase_mc), .meas_ttime_fx(meas_ttime_fx),
		.busy(busy), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data));
	smf_term_model term_u (.mclk(mclk), .arst_n(arst_n),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.stall(stall));

	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	// field k of block b for channel c, made up but within legal ranges
	function automatic logic [63:0] fv(int k, logic [3:0] c, int b);
		case (k)
			0: return 64'(8'h40 + c * 4 + b);
			1: return 64'(8'h16 + b);
			2: return 64'(8'h1E + c + b);
			3: return 64'hC0DE_0123_4567_89A0 + c * 16 + b;
			4: return 64'h3F50_0000_0000_0000 + c * 16 + b;
			5: return 64'(32'hFFFF_FF00 + c * 16 + b);
			default: return 64'({8'hC8, 1'b1, 23'h00_0100} + b);
		endcase
	endfunction

	always_comb begin
		meas_prn = {4'h0, meas_ch} + 8'h03;
		meas_az_deg = 9'h167 - {5'h00, meas_ch};
		for (int b = 0; b < 3; b++) begin
			meas_warn[b*8+:8] = 8'(fv(0, meas_ch, b));
			meas_qual[b*8+:8] = 8'(fv(1, meas_ch, b));
			meas_snr[b*8+:8] = 8'(fv(2, meas_ch, b));
			meas_phase[b*64+:64] = fv(3, meas_ch, b);
			meas_range[b*64+:64] = fv(4, meas_ch, b);
			meas_dopp[b*32+:32] = 32'(fv(5, meas_ch, b));
			meas_smooth[b*32+:32] = 32'(fv(6, meas_ch, b));
			meas_phase_mc[b*64+:64] = b == 0 ? 64'hFFFF_FFFF_FFFF_FF85 :
				64'h3039 + b;
			meas_ttime_fx[b*64+:64] = 64'h0098_9680 + b;
		end
	end

	// engine answers four cycles after each request
	always @(negedge mclk) begin
		if (meas_ack || !meas_req) begin
			meas_ack <= 1'b0;
			dly <= 2'h0;
		end else if (dly == 2'h3) begin
			meas_ack <= 1'b1;
		end else begin
			dly <= dly + 2'h1;
		end
	end

	task automatic close_out();
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (e !== g) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic epoch(logic a, logic [11:0] t);
		ep_cyc = cyc;
		ascii_mode = a;
		trk = t;
		epoch_start = 1'b1;
		@(negedge mclk);
		epoch_start = 1'b0;
	endtask

	// framer idle and output drained for 40 cycles in a row
	task automatic settle();
		int idle;
		int n;
		idle = 0;
		n = 0;
		while (idle < 40) begin
			@(negedge mclk);
			idle = (busy === 1'b0 && tx_valid === 1'b0) ? idle + 1 : 0;
			n++;
			if (n > 30000) begin
				fails++;
				close_out();
			end
		end
	endtask

	task automatic chk_hdr(int s);
		for (int i = 0; i < 11; i++) begin
			chk8("header", 8'(`SMF_HDR >> (80 - 8 * i)), term_u.q[s+i]);
		end
	endtask

	task automatic chk_bin(int s, logic [3:0] c, logic [7:0] rem,
		logic [7:0] ev, logic [15:0] et);
		logic [7:0] e[94];
		logic [7:0] x;
		logic [63:0] v;
		int p;
		chk_hdr(s);
		e[0] = et[15:8];
		e[1] = et[7:0];
		e[2] = rem;
		e[3] = {4'h0, c} + 8'h03;
		e[4] = ev;
		e[5] = 8'((9'h167 - c) >> 1);
		e[6] = {4'h0, c};
		p = 7;
		for (int b = 0; b < 3; b++) begin
			e[p] = 8'(fv(0, c, b));
			e[p+1] = 8'(fv(1, c, b));
			e[p+2] = 8'h05;
			e[p+3] = 8'(fv(2, c, b));
			e[p+4] = 8'h00;
			p = p + 5;
			for (int f = 3; f < 7; f++) begin
				v = fv(f, c, b) << (f < 5 ? 0 : 32);
				for (int k = 0; k < (f < 5 ? 8 : 4); k++) begin
					e[p] = v[63-8*k-:8];
					p++;
				end
			end
		end
		x = 8'h00;
		for (int i = 0; i < 94; i++) begin
			chk8("data", e[i], term_u.q[s+11+i]);
			x = x ^ e[i];
		end
		chk8("checksum", x, term_u.q[s+105]);
		chk8("cr", 8'h0D, term_u.q[s+106]);
		chk8("lf", 8'h0A, term_u.q[s+107]);
	endtask

	// ch1 and ch12 qualify, ch2 sits on the mask; a second start is ignored
	task automatic s_binary();
		int s;
		logic [15:0] et;
		s = term_u.q.size();
		stall = 1'b1;
		elev = '0;
		elev[7:0] = 8'h2D;
		elev[15:8] = 8'h0A;
		elev[95:88] = 8'h5A;
		// let a few tag periods pass so the expected tag is not zero
		repeat (20) @(negedge mclk);
		epoch(1'b0, 12'h803);
		et = 16'((ep_cyc - rel_cyc) / TC);
		repeat (3) @(negedge mclk);
		epoch(1'b0, 12'h803);
		settle();
		chk8("bytes", 8'd216, 8'(term_u.q.size() - s));
		chk_bin(s, 4'h1, 8'h01, 8'h2D, et);
		chk_bin(s + 108, 4'hC, 8'h00, 8'h5A, et);
		chk8("tag hi", term_u.q[s+11], term_u.q[s+119]);
		chk8("tag lo", term_u.q[s+12], term_u.q[s+120]);
	endtask

	// one text record for ch5: fields counted, a few read, checksum redone
	task automatic s_ascii();
		int s;
		int p[$];
		logic [7:0] x;
		s = term_u.q.size();
		stall = 1'b0;
		elev[39:32] = 8'h14;
		epoch(1'b1, 12'h010);
		settle();
		chk_hdr(s);
		for (int i = s + 11; i < term_u.q.size() - 5; i++) begin
			if (term_u.q[i] == 8'h2C) begin
				p.push_back(i);
			end
		end
		chk8("fields", 8'd36, 8'(p.size()));
		if (p.size() == 36) begin
			chk8("remaining", 8'h30, term_u.q[p[0]+1]);
			chk8("prn", 8'h38, term_u.q[p[1]+1]);
			chk8("elev d1", 8'h32, term_u.q[p[2]+1]);
			chk8("elev d0", 8'h30, term_u.q[p[2]+2]);
			chk8("az d2", 8'h33, term_u.q[p[3]+1]);
			chk8("az d1", 8'h35, term_u.q[p[3]+2]);
			chk8("az d0", 8'h34, term_u.q[p[3]+3]);
			chk8("az end", 8'h2C, term_u.q[p[3]+4]);
			chk8("channel", 8'h35, term_u.q[p[4]+1]);
			chk8("compat", 8'h35, term_u.q[p[7]+1]);
			x = 8'h00;
			for (int i = s + 11; i <= p[35]; i++) begin
				x = x ^ term_u.q[i];
			end
			chk8("ck d2", 8'h30 + x / 100, term_u.q[p[35]+1]);
			chk8("ck d1", 8'h30 + x / 10 % 10, term_u.q[p[35]+2]);
			chk8("ck d0", 8'h30 + x % 10, term_u.q[p[35]+3]);
			chk8("cr", 8'h0D, term_u.q[p[35]+4]);
			chk8("lf", 8'h0A, term_u.q[p[35]+5]);
			chk8("end", 8'(p[35] + 6), 8'(term_u.q.size()));
		end
	endtask

	// reset in mid-record: block idles at once and after the release
	task automatic s_reset();
		stall = 1'b1;
		epoch(1'b0, 12'h803);
		chk8("busy on", 8'h01, {7'h00, busy});
		repeat (30) @(negedge mclk);
		arst_n = 1'b0;
		@(negedge mclk);
		chk8("busy rst", 8'h00, {7'h00, busy});
		chk8("valid rst", 8'h00, {7'h00, tx_valid});
		@(negedge mclk);
		arst_n = 1'b1;
		rel_cyc = cyc;
		@(negedge mclk);
		chk8("req rel", 8'h00, {7'h00, meas_req});
		chk8("busy rel", 8'h00, {7'h00, busy});
		chk8("valid rel", 8'h00, {7'h00, tx_valid});
		stall = 1'b0;
		settle();
	endtask

	// two epochs 800 cycles apart: 100 ticks of 8 cycles
	task automatic s_tag();
		int s;
		int c1;
		logic [15:0] t1;
		logic [15:0] t2;
		s = term_u.q.size();
		c1 = cyc;
		epoch(1'b0, 12'h001);
		settle();
		while (cyc < c1 + 800) begin
			@(negedge mclk);
		end
		epoch(1'b0, 12'h001);
		settle();
		t1 = {term_u.q[s+11], term_u.q[s+12]};
		t2 = {term_u.q[s+119], term_u.q[s+120]};
		chk8("tag step", 8'h64, 8'(t2 - t1));
	endtask

	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		ascii_mode = 1'b0;
		epoch_start = 1'b0;
		trk = '0;
		elev = '0;
		elev_mask = 8'h0A;
		stall = 1'b0;
		meas_ack = 1'b0;
		dly = 2'h0;
		repeat (5) @(negedge mclk);
		arst_n = 1'b1;
		rel_cyc = cyc;
		@(negedge mclk);
		s_binary();
		s_ascii();
		s_reset();
		s_tag();
		close_out();
	end
endmodule
